//--- design/debug_serial_unit.sv
// debug serial unit: AHB-Lite register file, control and status around the engines
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module debug_serial_unit import debug_serial_pkg::*; #(
  parameter logic [31:0] CHIP_ID = 32'h0000_0001,  // arbitrary value
  parameter logic [31:0] CHIP_ID_EXT = 32'h0000_0000  // arbitrary value
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // serial pins
  input wire logic SERIAL_RX_PIN,
  output logic SERIAL_TX_PIN,
  // transfer channel and debug channel flags
  input wire logic RX_TRANSFER_END,
  input wire logic TX_TRANSFER_END,
  input wire logic TX_BUFFER_EMPTY,
  input wire logic RX_BUFFER_FULL,
  input wire logic DBGCHAN_WRITE_PENDING,
  input wire logic DBGCHAN_READ_PENDING,
  // tap reset control
  output logic TAP_RESET_FORCE
);
  bus_req_t req_r;
  logic take;
  logic [31:0] mode_r;
  logic [31:0] mask_r;
  logic [15:0] baud_r;
  logic [15:0] baud_cnt_r;
  logic tick_r;
  logic rx_en_r;
  logic rx_dis_pend_r;
  logic tx_en_r;
  logic tx_dis_pend_r;
  logic thr_full_r;
  logic [7:0] thr_data_r;
  logic rx_ready_r;
  logic [7:0] rhr_r;
  logic overrun_r;
  logic framing_r;
  logic parity_r;
  logic [31:0] status;
  logic [31:0] read_mux;
  logic rx_rst_cmd;
  logic tx_rst_cmd;
  logic rx_en_cmd;
  logic rx_dis_cmd;
  logic tx_en_cmd;
  logic tx_dis_cmd;
  logic status_clear_cmd;
  logic thr_write;
  logic rhr_read;
  logic [2:0] parity_type;
  channel_mode_t channel_mode;
  logic rx_run;
  logic tx_run;
  logic tx_load;
  logic tx_busy;
  logic tx_line;
  logic rx_busy;
  logic rx_done;
  logic rx_line;
  rx_result_t rx_res;

  // write in the data phase of a transfer latched at its address phase
  function automatic logic wr_hit(input bus_req_t r, input logic [7:0] off);
    return r.valid && r.write && (r.addr == off);
  endfunction : wr_hit

  assign take = HSEL && HTRANS[1] && HREADY;
  assign rx_rst_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_RX_RESET];
  assign tx_rst_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_TX_RESET];
  assign rx_en_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_RX_ENABLE];
  assign rx_dis_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_RX_DISABLE];
  assign tx_en_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_TX_ENABLE];
  assign tx_dis_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_TX_DISABLE];
  assign status_clear_cmd = wr_hit(req_r, OFF_CONTROL) && HWDATA[CR_STATUS_CLEAR];
  assign thr_write = wr_hit(req_r, OFF_TX_HOLDING);
  assign rhr_read = take && !HWRITE && (HADDR[7:0] == OFF_RX_HOLDING);

  // bus address phase capture; zero wait states, always OKAY
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      req_r <= '0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      req_r.valid <= take;
      req_r.write <= HWRITE;
      req_r.addr <= HADDR[7:0];
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end

  // mode, baud divisor and tap reset force
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r <= MODE_RESET;
      baud_r <= BAUD_RESET;
      TAP_RESET_FORCE <= 1'b0;
    end else begin
      if (wr_hit(req_r, OFF_MODE)) mode_r <= HWDATA & MODE_BITS;
      if (wr_hit(req_r, OFF_BAUD_DIVISOR)) baud_r <= HWDATA[15:0];
      if (wr_hit(req_r, OFF_TAP_RESET_FORCE)) TAP_RESET_FORCE <= HWDATA[0];
    end
  end

  assign parity_type = mode_r[MR_PARITY_LSB +: 3];
  assign channel_mode = channel_mode_t'(mode_r[MR_CHANNEL_MODE_LSB +: 2]);

  // interrupt mask: set and clear registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_r <= MASK_RESET;
    end else if (wr_hit(req_r, OFF_IRQ_ENABLE)) begin
      mask_r <= (mask_r | HWDATA) & IRQ_BITS;
    end else if (wr_hit(req_r, OFF_IRQ_DISABLE)) begin
      mask_r <= mask_r & ~HWDATA;
    end
  end

  // 16x sample tick; divisor 0 stops the serial clock
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      baud_cnt_r <= 16'h0;
      tick_r <= 1'b0;
    end else if (baud_r == 16'h0) begin
      baud_cnt_r <= 16'h0;
      tick_r <= 1'b0;
    end else if (baud_cnt_r >= baud_r - 16'h1) begin
      baud_cnt_r <= 16'h0;
      tick_r <= 1'b1;
    end else begin
      baud_cnt_r <= baud_cnt_r + 16'h1;
      tick_r <= 1'b0;
    end
  end

  // receiver enable state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_en_r <= 1'b0;
      rx_dis_pend_r <= 1'b0;
    end else if (rx_rst_cmd) begin
      rx_en_r <= 1'b0;
      rx_dis_pend_r <= 1'b0;
    end else if (rx_dis_cmd) begin
      // a character in flight is finished before the receiver stops
      rx_dis_pend_r <= rx_busy;
      if (!rx_busy) rx_en_r <= 1'b0;
    end else if (rx_en_cmd) begin
      rx_en_r <= 1'b1;
      rx_dis_pend_r <= 1'b0;
    end else if (rx_dis_pend_r && !rx_busy) begin
      rx_en_r <= 1'b0;
      rx_dis_pend_r <= 1'b0;
    end
  end

  // transmitter enable state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_en_r <= 1'b0;
      tx_dis_pend_r <= 1'b0;
    end else if (tx_rst_cmd) begin
      tx_en_r <= 1'b0;
      tx_dis_pend_r <= 1'b0;
    end else if (tx_dis_cmd) begin
      // shifter and holding character both drain first
      tx_dis_pend_r <= tx_busy || thr_full_r;
      if (!(tx_busy || thr_full_r)) tx_en_r <= 1'b0;
    end else if (tx_en_cmd) begin
      tx_en_r <= 1'b1;
      tx_dis_pend_r <= 1'b0;
    end else if (tx_dis_pend_r && !tx_busy && !thr_full_r) begin
      tx_en_r <= 1'b0;
      tx_dis_pend_r <= 1'b0;
    end
  end

  // remote loopback keeps both engines out of the path
  assign rx_run = rx_en_r && (channel_mode != CH_REMOTE_LOOP);
  assign tx_run = tx_en_r && (channel_mode != CH_REMOTE_LOOP);
  assign tx_load = tx_run && thr_full_r && !tx_busy && !tx_rst_cmd;

  // transmit holding register; writes while disabled are dropped
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      thr_full_r <= 1'b0;
      thr_data_r <= 8'h0;
    end else if (tx_rst_cmd) begin
      thr_full_r <= 1'b0;
    end else if (thr_write && tx_en_r) begin
      // a write in the load cycle refills; the shifter took the old byte
      thr_full_r <= 1'b1;
      thr_data_r <= HWDATA[7:0];
    end else if (tx_load) begin
      thr_full_r <= 1'b0;
    end
  end

  // receive holding register and ready flag; new data wins over a read
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_ready_r <= 1'b0;
      rhr_r <= 8'h0;
    end else if (rx_done) begin
      rx_ready_r <= 1'b1;
      rhr_r <= rx_res.data;
    end else if (rhr_read) begin
      rx_ready_r <= 1'b0;
    end
  end

  // sticky error flags; a set in the clear cycle is kept
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
      parity_r <= 1'b0;
    end else begin
      if (rx_done && rx_ready_r && !rhr_read) overrun_r <= 1'b1;
      else if (status_clear_cmd) overrun_r <= 1'b0;
      if (rx_done && rx_res.framing_error) framing_r <= 1'b1;
      else if (status_clear_cmd) framing_r <= 1'b0;
      if (rx_done && rx_res.parity_error) parity_r <= 1'b1;
      else if (status_clear_cmd) parity_r <= 1'b0;
    end
  end

  // serial path routing per channel mode
  assign rx_line = (channel_mode == CH_LOCAL_LOOP) ? tx_line : SERIAL_RX_PIN;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SERIAL_TX_PIN <= 1'b1;
    end else begin
      unique case (channel_mode)
        CH_NORMAL: SERIAL_TX_PIN <= tx_line;
        CH_ECHO: SERIAL_TX_PIN <= SERIAL_RX_PIN;
        CH_LOCAL_LOOP: SERIAL_TX_PIN <= 1'b1;
        CH_REMOTE_LOOP: SERIAL_TX_PIN <= SERIAL_RX_PIN;
      endcase
    end
  end

  serial_tx_engine u_tx (
    .clk(CLK),
    .rst_n(RESET_N),
    .tick(tick_r),
    .abort(tx_rst_cmd),
    .load(tx_load),
    .load_data(thr_data_r),
    .parity_type(parity_type),
    .busy(tx_busy),
    .line(tx_line)
  );

  serial_rx_engine u_rx (
    .clk(CLK),
    .rst_n(RESET_N),
    .tick(tick_r),
    .abort(rx_rst_cmd),
    .run(rx_run),
    .line(rx_line),
    .parity_type(parity_type),
    .busy(rx_busy),
    .done(rx_done),
    .result(rx_res)
  );

  // status word
  always_comb begin
    status = 32'h0;
    status[SR_RX_READY] = rx_ready_r && rx_en_r;
    status[SR_TX_READY] = tx_en_r && !thr_full_r;
    status[SR_RX_TRANSFER_END] = RX_TRANSFER_END;
    status[SR_TX_TRANSFER_END] = TX_TRANSFER_END;
    status[SR_OVERRUN] = overrun_r;
    status[SR_FRAMING] = framing_r;
    status[SR_PARITY] = parity_r;
    status[SR_TX_IDLE_EMPTY] = tx_en_r && !thr_full_r && !tx_busy;
    status[SR_TX_BUFFER_EMPTY] = TX_BUFFER_EMPTY;
    status[SR_RX_BUFFER_FULL] = RX_BUFFER_FULL;
    status[SR_DBGCHAN_WRITE] = DBGCHAN_WRITE_PENDING;
    status[SR_DBGCHAN_READ] = DBGCHAN_READ_PENDING;
  end

  // read decode; write-only and unmapped words read zero
  always_comb begin
    read_mux = 32'h0;
    unique case (HADDR[7:0])
      OFF_MODE: read_mux = mode_r;
      OFF_IRQ_MASK: read_mux = mask_r;
      OFF_STATUS: read_mux = status;
      OFF_RX_HOLDING: read_mux = {24'h0, rhr_r};
      OFF_BAUD_DIVISOR: read_mux = {16'h0, baud_r};
      OFF_CHIP_IDENTITY: read_mux = CHIP_ID;
      OFF_CHIP_IDENTITY_EXT: read_mux = CHIP_ID_EXT;
      OFF_TAP_RESET_FORCE: read_mux = {31'h0, TAP_RESET_FORCE};
      default: read_mux = 32'h0;
    endcase
  end

  // read data is captured at the address edge so it stands the whole data phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0;
    end else if (take && !HWRITE) begin
      HRDATA <= read_mux;
    end
  end
endmodule : debug_serial_unit

//--- design/debug_serial_pkg.sv
// shared constants, types and helpers of the debug serial unit
package debug_serial_pkg;
  // register offsets (low address byte)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h08;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_RX_HOLDING = 8'h18;
  localparam logic [7:0] OFF_TX_HOLDING = 8'h1c;
  localparam logic [7:0] OFF_BAUD_DIVISOR = 8'h20;
  localparam logic [7:0] OFF_CHIP_IDENTITY = 8'h40;
  localparam logic [7:0] OFF_CHIP_IDENTITY_EXT = 8'h44;
  localparam logic [7:0] OFF_TAP_RESET_FORCE = 8'h48;
  // control bits
  localparam int CR_RX_RESET = 2;
  localparam int CR_TX_RESET = 3;
  localparam int CR_RX_ENABLE = 4;
  localparam int CR_RX_DISABLE = 5;
  localparam int CR_TX_ENABLE = 6;
  localparam int CR_TX_DISABLE = 7;
  localparam int CR_STATUS_CLEAR = 8;
  // mode fields
  localparam int MR_PARITY_LSB = 9;
  localparam int MR_CHANNEL_MODE_LSB = 14;
  localparam logic [31:0] MODE_RESET = 32'h0;
  localparam logic [31:0] MODE_BITS = 32'h0000_ce00;
  // status bits
  localparam int SR_RX_READY = 0;
  localparam int SR_TX_READY = 1;
  localparam int SR_RX_TRANSFER_END = 3;
  localparam int SR_TX_TRANSFER_END = 4;
  localparam int SR_OVERRUN = 5;
  localparam int SR_FRAMING = 6;
  localparam int SR_PARITY = 7;
  localparam int SR_TX_IDLE_EMPTY = 9;
  localparam int SR_TX_BUFFER_EMPTY = 11;
  localparam int SR_RX_BUFFER_FULL = 12;
  localparam int SR_DBGCHAN_WRITE = 30;
  localparam int SR_DBGCHAN_READ = 31;
  localparam logic [31:0] IRQ_BITS = 32'hc000_1afb;
  localparam logic [31:0] MASK_RESET = 32'h0;
  localparam logic [15:0] BAUD_RESET = 16'h0;
  // serial timing: sixteen divider ticks per bit, sampling at mid-bit
  localparam logic [3:0] BIT_TICKS_LAST = 4'hf;
  localparam logic [3:0] HALF_TICKS_LAST = 4'h7;
  localparam logic [3:0] FRAME_BITS_PAR = 4'hb;
  localparam logic [3:0] FRAME_BITS_NOPAR = 4'ha;

  typedef enum logic [1:0] {
    CH_NORMAL = 2'b00,
    CH_ECHO = 2'b01,
    CH_LOCAL_LOOP = 2'b10,
    CH_REMOTE_LOOP = 2'b11
  } channel_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } bus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic parity_error;
    logic framing_error;
  } rx_result_t;

  function automatic logic parity_on(input logic [2:0] parity_type);
    return ~parity_type[2];
  endfunction : parity_on

  function automatic logic parity_calc(input logic [7:0] d, input logic [2:0] parity_type);
    logic p;
    unique case (parity_type[1:0])
      2'b00: p = ^d;
      2'b01: p = ~^d;
      2'b10: p = 1'b0;
      default: p = 1'b1;
    endcase
    return p;
  endfunction : parity_calc
endpackage : debug_serial_pkg

//--- design/serial_tx_engine.sv
// character shifter of the transmit side
`timescale 1ns/1ps
module serial_tx_engine import debug_serial_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic abort,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic [2:0] parity_type,
  // state and line
  output logic busy,
  output logic line
);
  typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} tx_state_t;
  tx_state_t state_r;
  logic [10:0] frame_r;
  logic [3:0] bits_left_r;
  logic [3:0] tick_cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TX_IDLE;
      frame_r <= 11'h7ff;
      bits_left_r <= 4'h0;
      tick_cnt_r <= 4'h0;
    end else if (abort) begin
      state_r <= TX_IDLE;
      frame_r <= 11'h7ff;
    end else begin
      unique case (state_r)
        TX_IDLE: if (load) begin
          // start low, data lsb first, optional parity, stop high
          if (parity_on(parity_type)) begin
            frame_r <= {1'b1, parity_calc(load_data, parity_type), load_data, 1'b0};
            bits_left_r <= FRAME_BITS_PAR;
          end else begin
            frame_r <= {2'b11, load_data, 1'b0};
            bits_left_r <= FRAME_BITS_NOPAR;
          end
          tick_cnt_r <= 4'h0;
          state_r <= TX_SHIFT;
        end
        TX_SHIFT: if (tick) begin
          tick_cnt_r <= tick_cnt_r + 4'h1;
          if (tick_cnt_r == BIT_TICKS_LAST) begin
            frame_r <= {1'b1, frame_r[10:1]};
            bits_left_r <= bits_left_r - 4'h1;
            if (bits_left_r == 4'h1) state_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign busy = (state_r == TX_SHIFT);
  assign line = (state_r == TX_SHIFT) ? frame_r[0] : 1'b1;
endmodule : serial_tx_engine

//--- design/serial_rx_engine.sv
// character sampler of the receive side
`timescale 1ns/1ps
module serial_rx_engine import debug_serial_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic abort,
  input wire logic run,
  input wire logic line,
  input wire logic [2:0] parity_type,
  // result
  output logic busy,
  output logic done,
  output rx_result_t result
);
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10} rx_state_t;
  rx_state_t state_r;
  logic [9:0] bits_r;
  logic [3:0] idx_r;
  logic [3:0] tick_cnt_r;
  logic [3:0] last_idx;

  // index of the stop bit among the sampled bits
  assign last_idx = parity_on(parity_type) ? (FRAME_BITS_PAR - 4'h2) : (FRAME_BITS_NOPAR - 4'h2);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RX_IDLE;
      bits_r <= 10'h0;
      idx_r <= 4'h0;
      tick_cnt_r <= 4'h0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        state_r <= RX_IDLE;
      end else begin
        unique case (state_r)
          RX_IDLE: if (run && !line) begin
            state_r <= RX_START;
            tick_cnt_r <= 4'h0;
          end
          RX_START: if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            if (tick_cnt_r == HALF_TICKS_LAST) begin
              // a start bit gone high at mid-bit was a glitch
              state_r <= line ? RX_IDLE : RX_BITS;
              tick_cnt_r <= 4'h0;
              idx_r <= 4'h0;
            end
          end
          RX_BITS: if (tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
            if (tick_cnt_r == BIT_TICKS_LAST) begin
              bits_r[idx_r] <= line;
              idx_r <= idx_r + 4'h1;
              if (idx_r == last_idx) begin
                state_r <= RX_IDLE;
                done <= 1'b1;
                result.data <= bits_r[7:0];
                result.parity_error <= parity_on(parity_type) &&
                  (bits_r[8] != parity_calc(bits_r[7:0], parity_type));
                result.framing_error <= ~line;
              end
            end
          end
          default: state_r <= RX_IDLE;
        endcase
      end
    end
  end

  assign busy = (state_r != RX_IDLE);
endmodule : serial_rx_engine

//--- verif/debug_serial_unit_properties.sv
// concurrent checks on the debug serial unit ports
`timescale 1ns/1ps
module debug_serial_unit_properties import debug_serial_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // bus
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // line and flags
  input wire logic SERIAL_TX_PIN,
  input wire logic RX_TRANSFER_END,
  input wire logic TX_TRANSFER_END,
  input wire logic TX_BUFFER_EMPTY,
  input wire logic RX_BUFFER_FULL,
  input wire logic DBGCHAN_WRITE_PENDING,
  input wire logic DBGCHAN_READ_PENDING
);
  logic rd_r;
  logic wr_r;
  logic [7:0] ad_r;
  logic [31:0] mode_r;
  logic [31:0] mask_r;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      ad_r <= 8'h00;
    end else begin
      rd_r <= HSEL & HTRANS[1] & HREADY & !HWRITE;
      wr_r <= HSEL & HTRANS[1] & HREADY & HWRITE;
      ad_r <= HADDR[7:0];
    end
  end
  // shadows follow the data phase, so a back-to-back read still sees the old value
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_r <= MODE_RESET;
      mask_r <= MASK_RESET;
    end else if (wr_r && ad_r == OFF_MODE) begin
      mode_r <= HWDATA & MODE_BITS;
    end else if (wr_r && ad_r == OFF_IRQ_ENABLE) begin
      mask_r <= mask_r | (HWDATA & IRQ_BITS);
    end else if (wr_r && ad_r == OFF_IRQ_DISABLE) begin
      mask_r <= mask_r & ~HWDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  end_mirror_a: assert property (rd_r && ad_r == OFF_STATUS |->
    HRDATA[4:3] == {$past(TX_TRANSFER_END), $past(RX_TRANSFER_END)})
    else $error("transfer end bits wrong");
  buf_mirror_a: assert property (rd_r && ad_r == OFF_STATUS |->
    HRDATA[12:11] == {$past(RX_BUFFER_FULL), $past(TX_BUFFER_EMPTY)})
    else $error("buffer bits wrong");
  dbg_mirror_a: assert property (rd_r && ad_r == OFF_STATUS |->
    HRDATA[31:30] == {$past(DBGCHAN_READ_PENDING), $past(DBGCHAN_WRITE_PENDING)})
    else $error("debug channel bits wrong");
  empty_ready_a: assert property (rd_r && ad_r == OFF_STATUS |->
    !HRDATA[9] || HRDATA[1])
    else $error("empty without ready");
  mask_read_a: assert property (rd_r && ad_r == OFF_IRQ_MASK |->
    HRDATA == $past(mask_r))
    else $error("mask readback wrong");
  mode_read_a: assert property (rd_r && ad_r == OFF_MODE |->
    HRDATA == $past(mode_r))
    else $error("mode readback wrong");
  rx_upper_a: assert property (rd_r && ad_r == OFF_RX_HOLDING |->
    HRDATA[31:8] == 24'h0)
    else $error("holding upper bits set");
  loop_idle_a: assert property (mode_r[15:14] == 2'b10 &&
    $past(mode_r[15:14]) == 2'b10 |-> SERIAL_TX_PIN)
    else $error("pin not idle in local loop");
endmodule : debug_serial_unit_properties

bind debug_serial_unit debug_serial_unit_properties debug_serial_unit_properties_inst (
  .CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY, .HRDATA,
  .HREADYOUT, .HRESP, .SERIAL_TX_PIN, .RX_TRANSFER_END, .TX_TRANSFER_END,
  .TX_BUFFER_EMPTY, .RX_BUFFER_FULL, .DBGCHAN_WRITE_PENDING, .DBGCHAN_READ_PENDING
);

//--- verif/serial_host.sv
// serial host model on the far side of the two-wire line, divisor 1
`timescale 1ns/1ps
module serial_host (
  // clock
  input wire logic clk,
  // line
  input wire logic tx_pin,
  output logic rx_pin
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial rx_pin = 1'b1;
  // bits leave lsb first, sixteen clocks each; caller builds start and stop
  task automatic send(input logic [10:0] f);
    for (int i = 0; i < 11; i++) begin
      rx_pin <= f[i];
      repeat (16) @(posedge clk);
    end
  endtask : send
  // mid-bit sampling; a frame with a low stop is dropped
  always begin
    @(negedge tx_pin);
    repeat (8) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (16) @(posedge clk);
      sh[i] = tx_pin;
    end
    repeat (16) @(posedge clk);
    if (tx_pin === 1'b1) got.push_back(sh);
  end
endmodule : serial_host

//--- verif/debug_serial_unit_tb.sv
// self-checking bench of the debug serial unit
`timescale 1ns/1ps
module debug_serial_unit_tb import debug_serial_pkg::*; ;
  logic CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'b00;
  logic HWRITE = 1'b0;
  logic [2:0] HSIZE = 3'b010;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic HREADYOUT, HRESP, SERIAL_RX_PIN, SERIAL_TX_PIN, TAP_RESET_FORCE;
  logic [5:0] flg = 6'h0;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] q, m, mk;
  logic [7:0] b;
  logic [7:0] txq[$];
  logic [7:0] ra[6] = '{OFF_MODE, OFF_IRQ_MASK, OFF_STATUS, OFF_RX_HOLDING,
    OFF_BAUD_DIVISOR, 8'h24};
  debug_serial_unit debug_serial_unit_inst (
    .CLK, .RESET_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
    .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .SERIAL_RX_PIN, .SERIAL_TX_PIN,
    .RX_TRANSFER_END(flg[0]), .TX_TRANSFER_END(flg[1]), .TX_BUFFER_EMPTY(flg[2]),
    .RX_BUFFER_FULL(flg[3]), .DBGCHAN_WRITE_PENDING(flg[4]),
    .DBGCHAN_READ_PENDING(flg[5]), .TAP_RESET_FORCE
  );
  serial_host serial_host_inst (.clk(CLK), .tx_pin(SERIAL_TX_PIN), .rx_pin(SERIAL_RX_PIN));
  always #12.5 CLK = ~CLK;
  function automatic logic [31:0] st(input logic [5:0] f, input logic [31:0] v);
    return {f[5:4], 17'h0, f[3:2], 6'h0, f[1:0], 3'h0} | v;
  endfunction : st
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h0, a};
    HWRITE <= w;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'b00;
    HWDATA <= d;
    do @(posedge CLK); while (HREADYOUT !== 1'b1);
    q = HRDATA;
  endtask : bus
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, q);
  endtask : rdc
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #500us;
    n_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h26f804f6));
    mk = 32'h0;
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    foreach (ra[i]) rdc("reset", ra[i], 32'h0);
    for (int i = 0; i < 6; i++) begin
      flg <= 6'($urandom);
      m = $urandom;
      bus(1'b1, OFF_IRQ_ENABLE, m);
      mk = mk | (m & IRQ_BITS);
      m = $urandom;
      bus(1'b1, OFF_IRQ_DISABLE, m);
      mk = mk & ~m;
      rdc("mask", OFF_IRQ_MASK, mk);
      rdc("status", OFF_STATUS, st(flg, 32'h0));
      m = $urandom;
      m[15] = (i == 0) ? 1'b1 : m[15];
      m[14] = (i == 0) ? 1'b0 : m[14];
      bus(1'b1, OFF_MODE, m);
      rdc("mode", OFF_MODE, m & MODE_BITS);
    end
    flg <= 6'h0;
    bus(1'b1, OFF_BAUD_DIVISOR, 32'h1);
    bus(1'b1, OFF_MODE, 32'h800);
    bus(1'b1, OFF_CONTROL, 32'hf0);
    rdc("both", OFF_STATUS, 32'h0);
    bus(1'b1, OFF_CONTROL, 32'h50);
    rdc("idle", OFF_STATUS, 32'h202);
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      txq.push_back(b);
      bus(1'b1, OFF_TX_HOLDING, {24'h0, b});
    end
    rdc("tx busy", OFF_STATUS, 32'h0);
    // disable mid-character: both queued characters must still leave
    bus(1'b1, OFF_CONTROL, 32'h80);
    for (int i = 0; i < 1000 && serial_host_inst.got.size() < 2; i++) @(posedge CLK);
    chk("tx count", 32'h2, 32'(serial_host_inst.got.size()));
    foreach (txq[i]) chk("tx", {24'h0, txq[i]}, {24'h0, serial_host_inst.got[i]});
    repeat (20) @(posedge CLK);
    rdc("tx off", OFF_STATUS, 32'h0);
    b = 8'($urandom);
    serial_host_inst.send({2'b11, b, 1'b0});
    rdc("rx ready", OFF_STATUS, 32'h1);
    rdc("rx char", OFF_RX_HOLDING, {24'h0, b});
    rdc("rx read", OFF_STATUS, 32'h0);
    serial_host_inst.send({2'b11, b, 1'b0});
    serial_host_inst.send({2'b10, ~b, 1'b0});
    rdc("overrun", OFF_STATUS, 32'h61);
    rdc("last", OFF_RX_HOLDING, {24'h0, ~b});
    bus(1'b1, OFF_MODE, 32'h0);
    serial_host_inst.send({2'b11, b[7:1], ^b[7:1], 1'b0});
    rdc("parity", OFF_STATUS, 32'he1);
    bus(1'b1, OFF_CONTROL, 32'h100);
    rdc("clear", OFF_STATUS, 32'h1);
    rdc("drain", OFF_RX_HOLDING, {24'h0, b[7:1], ^b[7:1]});
    fork
      serial_host_inst.send({2'b11, b, 1'b0});
      begin
        repeat (60) @(posedge CLK);
        bus(1'b1, OFF_CONTROL, 32'h4);
      end
    join
    bus(1'b1, OFF_CONTROL, 32'h10);
    rdc("rx abort", OFF_STATUS, 32'h0);
    // one byte in the shifter, one in holding, then a transmitter reset drops both
    bus(1'b1, OFF_CONTROL, 32'h40);
    bus(1'b1, OFF_TX_HOLDING, {24'h0, b});
    bus(1'b1, OFF_TX_HOLDING, {24'h0, ~b});
    bus(1'b1, OFF_CONTROL, 32'h8);
    rdc("tx reset", OFF_STATUS, 32'h0);
    bus(1'b1, OFF_CONTROL, 32'h40);
    rdc("tx abort", OFF_STATUS, 32'h202);
    // local loop: the byte comes back inside while the pin idles
    b = 8'($urandom);
    bus(1'b1, OFF_MODE, 32'h8800);
    bus(1'b1, OFF_TX_HOLDING, {24'h0, b});
    repeat (200) @(posedge CLK);
    rdc("loop", OFF_RX_HOLDING, {24'h0, b});
    // echo: the host hears its own frame back
    bus(1'b1, OFF_MODE, 32'h4800);
    serial_host_inst.send({2'b11, ~b, 1'b0});
    chk("echo", {24'h0, ~b}, {24'h0, serial_host_inst.got[$]});
    wrap_up();
  end
endmodule : debug_serial_unit_tb
